//--- core/sbt_top.sv
// bit timing recovery: input stage, add-subtract logic, bit timer, regenerator
//
// Decided for this implementation: the address map and the APB slave port.
`timescale 1ns/10ps
`include "sbt_cfg.svh"
module sbt_top (
	input  wire logic                   clock_i,
	input  wire logic                   rstn_i,
	input  wire logic                   psel_i,
	input  wire logic                   penable_i,
	input  wire logic                   pwrite_i,
	input  wire logic [`SBT_ADDR_W-1:0] paddr_i,
	input  wire logic [31:0]            pwdata_i,
	output logic [31:0]                 prdata_o,
	output logic                        pready_o,
	output logic                        pslverr_o,
	input  wire logic                   line_i,
	input  wire logic                   auto_sync_i,
	output logic                        data_o,
	output logic                        bit_timing_o,
	output logic                        regen_o,
	output logic                        regen_sync_o,
	output logic                        regen_ss_o,
	output sbt_pkg::sbt_count_t         bit_count_o
);
	import sbt_pkg::*;

	logic [31:0]           ctrl;
	logic                  corr_clr;
	logic [31:0]           stat;
	logic [31:0]           corr;
	logic                  tb_pulse;
	logic                  del_req, add_req;
	logic [`SBT_NCO_W-1:0] osc_inc;
	logic [1:0]            rate_sel;
	logic                  fixed_mode, fixed_sync, sync_mode;

	logic                  data_q, data_d;
	logic                  prev_q, prev_d;
	sbt_count_t            cnt_q, cnt_d;
	logic                  alt_q, alt_d;
	logic                  smp_q, smp_d;
	logic                  reg_q, reg_d;
	logic                  bt_q, bt_d;
	sbt_corr_t             last_q, last_d;
	logic [15:0]           adds_q, adds_d;
	logic [15:0]           subs_q, subs_d;
	logic                  ms_edge, early;

	// ----------------------------------------
	// oscillator pick
	// ----------------------------------------
	function automatic logic [`SBT_NCO_W-1:0] osc_pick(input logic [1:0] rate, input logic sync);
		logic [1:0] idx;
		idx = rate ^ {1'b0, sync};
		unique case (idx)
			2'h0: osc_pick = `SBT_NCO_W'(`SBT_INC(`SBT_OSC0_HZ));
			2'h1: osc_pick = `SBT_NCO_W'(`SBT_INC(`SBT_OSC1_HZ));
			2'h2: osc_pick = `SBT_NCO_W'(`SBT_INC(`SBT_OSC2_HZ));
			2'h3: osc_pick = `SBT_NCO_W'(`SBT_INC(`SBT_OSC3_HZ));
		endcase
	endfunction : osc_pick

	function automatic logic [15:0] sat_inc(input logic [15:0] v, input logic en);
		sat_inc = (en && v != 16'hFFFF) ? v + 16'h0001 : v;
	endfunction : sat_inc

	// ----------------------------------------
	// registers and mode
	// ----------------------------------------
	sbt_apb_regs u_regs (
		.clock_i    (clock_i),
		.rstn_i     (rstn_i),
		.psel_i     (psel_i),
		.penable_i  (penable_i),
		.pwrite_i   (pwrite_i),
		.paddr_i    (paddr_i),
		.pwdata_i   (pwdata_i),
		.prdata_o   (prdata_o),
		.pready_o   (pready_o),
		.pslverr_o  (pslverr_o),
		.stat_i     (stat),
		.corr_i     (corr),
		.ctrl_o     (ctrl),
		.corr_clr_o (corr_clr)
	);

	always_comb begin
		rate_sel     = ctrl[`SBT_CTRL_RATE_LSB +: 2];
		fixed_mode   = ctrl[`SBT_CTRL_FIXED_BIT];
		fixed_sync   = ctrl[`SBT_CTRL_FSYNC_BIT];
		sync_mode    = fixed_mode ? fixed_sync : auto_sync_i;
		regen_sync_o = sync_mode;
		regen_ss_o   = ~sync_mode;
		osc_inc      = osc_pick(rate_sel, sync_mode);
		stat         = {17'h00000, last_q, reg_q, bt_q, sync_mode, 1'b0, cnt_q};
		corr         = {subs_q, adds_q};
	end

	// ----------------------------------------
	// time-base
	// ----------------------------------------
	sbt_timebase u_tb (
		.clock_i    (clock_i),
		.rstn_i     (rstn_i),
		.osc_inc_i  (osc_inc),
		.div_i      (ctrl[`SBT_CTRL_DIV_LSB +: `SBT_DIV_W]),
		.del_req_i  (del_req),
		.add_req_i  (add_req),
		.tb_pulse_o (tb_pulse)
	);

	// ----------------------------------------
	// add-subtract and bit timer
	// ----------------------------------------
	always_comb begin
		data_d  = line_i;
		prev_d  = data_q;
		ms_edge = prev_q & ~data_q;
		// upper half of cycle means transition came before reference
		if (cnt_q == 7'h00) begin
			early = alt_q;
		end else begin
			early = cnt_q >= `SBT_BT_MID;
		end
		alt_d   = (ms_edge && cnt_q == 7'h00) ? ~alt_q : alt_q;
		del_req = ms_edge;
		add_req = ms_edge & early;
		last_d  = last_q;
		if (ms_edge) begin
			last_d = early ? SBT_CORR_ADD : SBT_CORR_SUB;
		end
		adds_d  = corr_clr ? 16'h0000 : adds_q;
		subs_d  = corr_clr ? 16'h0000 : subs_q;
		adds_d  = sat_inc(adds_d, add_req);
		subs_d  = sat_inc(subs_d, ms_edge & ~early);
		cnt_d   = tb_pulse ? cnt_q + 7'h01 : cnt_q;
		bt_d    = cnt_d < `SBT_BT_MID;
		smp_d   = smp_q;
		reg_d   = reg_q;
		if (tb_pulse && cnt_q == `SBT_BT_MID - 7'h01) begin
			smp_d = data_q;
		end
		if (tb_pulse && cnt_q == `SBT_BT_LAST) begin
			reg_d = smp_q;
		end
		data_o       = data_q;
		bit_timing_o = bt_q;
		regen_o      = reg_q;
		bit_count_o  = cnt_q;
	end

	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			data_q <= 1'b1;
			prev_q <= 1'b1;
			cnt_q  <= 7'h00;
			alt_q  <= 1'b0;
			smp_q  <= 1'b1;
			reg_q  <= 1'b1;
			bt_q   <= 1'b1;
			last_q <= SBT_CORR_NONE;
			adds_q <= 16'h0000;
			subs_q <= 16'h0000;
		end else begin
			data_q <= data_d;
			prev_q <= prev_d;
			cnt_q  <= cnt_d;
			alt_q  <= alt_d;
			smp_q  <= smp_d;
			reg_q  <= reg_d;
			bt_q   <= bt_d;
			last_q <= last_d;
			adds_q <= adds_d;
			subs_q <= subs_d;
		end
	end

endmodule : sbt_top

//--- shared/sbt_cfg.svh
// constants of the bit timing recovery block
`ifndef SBT_CFG_SVH
`define SBT_CFG_SVH

// ----------------------------------------
// clock and oscillators
// ----------------------------------------
`define SBT_CLK_HZ          64'd10000000
`define SBT_NCO_W           24
`define SBT_NCO_ONE         64'd16777216
`define SBT_OSC0_HZ         64'd76800
`define SBT_OSC1_HZ         64'd93230
`define SBT_OSC2_HZ         64'd125210
`define SBT_OSC3_HZ         64'd152016
`define SBT_INC(f)          (((f) * `SBT_NCO_ONE) / `SBT_CLK_HZ)

// ----------------------------------------
// bit timer
// ----------------------------------------
`define SBT_BT_W            7
`define SBT_BT_MID          7'h40
`define SBT_BT_LAST         7'h7F
`define SBT_DIV_W           4

// ----------------------------------------
// register map
// ----------------------------------------
`define SBT_ADDR_W          12
`define SBT_OFF_CTRL        12'h000
`define SBT_OFF_STAT        12'h004
`define SBT_OFF_CORR        12'h008
`define SBT_CTRL_RATE_LSB   0
`define SBT_CTRL_FIXED_BIT  2
`define SBT_CTRL_FSYNC_BIT  3
`define SBT_CTRL_DIV_LSB    8
`define SBT_CTRL_RST        32'h00000400
`define SBT_CTRL_MASK       32'h00000F0F

`endif

//--- shared/sbt_pkg.sv
// types of the bit timing recovery block
package sbt_pkg;

	// ----------------------------------------
	// last correction applied
	// ----------------------------------------
	typedef enum logic [2:0] {
		SBT_CORR_NONE = 3'b001,
		SBT_CORR_ADD  = 3'b010,
		SBT_CORR_SUB  = 3'b100
	} sbt_corr_t;

	typedef logic [6:0] sbt_count_t;

endpackage : sbt_pkg

//--- core/sbt_timebase.sv
// oscillator and time-base divider with pulse insert and delete
`timescale 1ns/10ps
`include "sbt_cfg.svh"
module sbt_timebase (
	input  wire logic                   clock_i,
	input  wire logic                   rstn_i,
	input  wire logic [`SBT_NCO_W-1:0]  osc_inc_i,
	input  wire logic [`SBT_DIV_W-1:0]  div_i,
	input  wire logic                   del_req_i,
	input  wire logic                   add_req_i,
	output logic                        tb_pulse_o
);
	import sbt_pkg::*;

	logic [`SBT_NCO_W-1:0] acc_q, acc_d;
	logic                  s1_q, s1_d;
	logic [`SBT_DIV_W-1:0] s2_q, s2_d;
	logic                  del_q, del_d;
	logic                  add_q, add_d;
	logic                  osc_tick, s1_tick, raw;

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		logic [`SBT_NCO_W:0]   sum;
		logic [`SBT_DIV_W:0]   s2n;
		logic [`SBT_DIV_W-1:0] dv;
		sum      = {1'b0, acc_q} + {1'b0, osc_inc_i};
		s2n      = {1'b0, s2_q};
		// zero divide acts as divide by one
		dv       = (div_i == '0) ? `SBT_DIV_W'(1) : div_i;
		osc_tick = sum[`SBT_NCO_W];
		acc_d    = sum[`SBT_NCO_W-1:0];
		s1_tick  = osc_tick & s1_q;
		s1_d     = s1_q ^ osc_tick;
		// second stage also takes the injected pulse
		s2n      = s2n + {4'h0, s1_tick} + {4'h0, add_req_i};
		raw      = 1'b0;
		if (s2n >= {1'b0, dv}) begin
			raw = 1'b1;
			s2n = s2n - {1'b0, dv};
		end
		s2_d = s2n[`SBT_DIV_W-1:0];
		// swallow one pulse per request
		tb_pulse_o = (raw & ~del_q) | (add_q & ~raw);
		del_d = del_req_i | (del_q & ~raw);
		add_d = add_req_i | (add_q & raw);
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			acc_q <= '0;
			s1_q  <= 1'b0;
			s2_q  <= '0;
			del_q <= 1'b0;
			add_q <= 1'b0;
		end else begin
			acc_q <= acc_d;
			s1_q  <= s1_d;
			s2_q  <= s2_d;
			del_q <= del_d;
			add_q <= add_d;
		end
	end

endmodule : sbt_timebase

//--- core/sbt_apb_regs.sv
// apb register slave of the bit timing recovery block
`timescale 1ns/10ps
`include "sbt_cfg.svh"
module sbt_apb_regs (
	input  wire logic                   clock_i,
	input  wire logic                   rstn_i,
	input  wire logic                   psel_i,
	input  wire logic                   penable_i,
	input  wire logic                   pwrite_i,
	input  wire logic [`SBT_ADDR_W-1:0] paddr_i,
	input  wire logic [31:0]            pwdata_i,
	output logic [31:0]                 prdata_o,
	output logic                        pready_o,
	output logic                        pslverr_o,
	input  wire logic [31:0]            stat_i,
	input  wire logic [31:0]            corr_i,
	output logic [31:0]                 ctrl_o,
	output logic                        corr_clr_o
);
	import sbt_pkg::*;

	logic [31:0] ctrl_q, ctrl_d;
	logic        acc, hit;

	// ----------------------------------------
	// decode and write
	// ----------------------------------------
	always_comb begin
		acc        = psel_i & penable_i;
		hit        = (paddr_i == `SBT_OFF_CTRL) | (paddr_i == `SBT_OFF_STAT) | (paddr_i == `SBT_OFF_CORR);
		pready_o   = 1'b1;
		pslverr_o  = acc & ~hit;
		ctrl_d     = ctrl_q;
		corr_clr_o = 1'b0;
		if (acc && pwrite_i && paddr_i == `SBT_OFF_CTRL) begin
			ctrl_d = pwdata_i & `SBT_CTRL_MASK;
		end
		if (acc && pwrite_i && paddr_i == `SBT_OFF_CORR) begin
			corr_clr_o = 1'b1;
		end
		unique case (paddr_i)
			`SBT_OFF_CTRL: prdata_o = ctrl_q;
			`SBT_OFF_STAT: prdata_o = stat_i;
			`SBT_OFF_CORR: prdata_o = corr_i;
			default:       prdata_o = 32'h00000000;
		endcase
		ctrl_o = ctrl_q;
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			ctrl_q <= `SBT_CTRL_RST;
		end else begin
			ctrl_q <= ctrl_d;
		end
	end

endmodule : sbt_apb_regs

//--- sim/sbt_top_sva.sv
// assertions on the ports of the bit timing recovery block
`timescale 1ns/10ps
`include "sbt_cfg.svh"
module sbt_top_sva (
	input wire logic                   clock_i,
	input wire logic                   rstn_i,
	input wire logic                   psel_i,
	input wire logic                   penable_i,
	input wire logic                   pwrite_i,
	input wire logic [`SBT_ADDR_W-1:0] paddr_i,
	input wire logic [31:0]            pwdata_i,
	input wire logic [31:0]            prdata_o,
	input wire logic                   pready_o,
	input wire logic                   pslverr_o,
	input wire logic                   line_i,
	input wire logic                   auto_sync_i,
	input wire logic                   data_o,
	input wire logic                   bit_timing_o,
	input wire logic                   regen_o,
	input wire logic                   regen_sync_o,
	input wire logic                   regen_ss_o,
	input wire sbt_pkg::sbt_count_t    bit_count_o
);
	import sbt_pkg::*;
	// ----------------------------------------
	// shadow of fixed mode bits
	// ----------------------------------------
	logic [1:0] mode_q;
	logic [1:0] mode_d;
	logic       acc;
	logic       mapped;
	assign acc = psel_i && penable_i;
	assign mapped = paddr_i == `SBT_OFF_CTRL || paddr_i == `SBT_OFF_STAT || paddr_i == `SBT_OFF_CORR;
	always_comb mode_d = (acc && pwrite_i && paddr_i == `SBT_OFF_CTRL) ? pwdata_i[3:2] : mode_q;
	always_ff @(posedge clock_i) mode_q <= rstn_i ? mode_d : 2'h0;
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rstn_i);
	sequence s_line_fall; line_i ##1 !line_i; endsequence
	sequence s_line_rise; !line_i ##1 line_i; endsequence
	a_data_fall: assert property (s_line_fall |=> !data_o) else $error("data did not fall");
	a_data_rise: assert property (s_line_rise |=> data_o) else $error("data did not rise");
	a_timing_half: assert property (bit_timing_o == (bit_count_o < 7'h40))
		else $error("bit timing not high in first half");
	a_count_step: assert property ($changed(bit_count_o) |-> bit_count_o == $past(bit_count_o) + 7'h01)
		else $error("bit count skipped");
	a_regen_wrap: assert property ($changed(regen_o) |-> bit_count_o == 7'h00)
		else $error("regen changed off wrap");
	a_one_mode: assert property (regen_sync_o != regen_ss_o) else $error("mode outputs clash");
	a_mode_sel: assert property (regen_sync_o == (mode_q[0] ? mode_q[1] : auto_sync_i))
		else $error("mode selection wrong");
	a_pready_one: assert property (acc |-> pready_o) else $error("pready low in access");
	a_slverr_map: assert property (acc |-> pslverr_o == !mapped) else $error("pslverr wrong");
	a_unmap_zero: assert property (acc && !mapped && !pwrite_i |-> prdata_o == 32'h0)
		else $error("unmapped read not zero");
endmodule : sbt_top_sva
bind sbt_top sbt_top_sva u_sva (.clock_i(clock_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i),
	.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
	.pslverr_o(pslverr_o), .line_i(line_i), .auto_sync_i(auto_sync_i), .data_o(data_o),
	.bit_timing_o(bit_timing_o), .regen_o(regen_o), .regen_sync_o(regen_sync_o), .regen_ss_o(regen_ss_o),
	.bit_count_o(bit_count_o));

//--- sim/sbt_line_model.sv
// incoming line: idles at mark, sends one space element on request
`timescale 1ns/10ps
module sbt_line_model #(
	parameter int SPACE_LEN = 300
) (
	input  wire logic clock_i,
	input  wire logic rstn_i,
	input  wire logic go_i,
	output logic      line_o
);
	int cnt_q;
	int cnt_d;
	always_comb cnt_d = go_i ? SPACE_LEN : (cnt_q != 0 ? cnt_q - 1 : 0);
	always_ff @(posedge clock_i) cnt_q <= rstn_i ? cnt_d : 0;
	assign line_o = (cnt_q == 0);
endmodule : sbt_line_model

//--- sim/sbt_top_tb.sv
// self-checking bench of the bit timing recovery block
`timescale 1ns/10ps
`include "sbt_cfg.svh"
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin err_count++; \
	$display("unexpected %s exp %0h got %0h", n, e, s); end end
module sbt_top_tb;
	import sbt_pkg::*;
	logic        clock_i, rstn_i, psel_i, penable_i, pwrite_i, auto_sync_i, go, line, er, exp_sync;
	logic [11:0] paddr_i;
	logic [31:0] pwdata_i, prdata_o, rd;
	logic        pready_o, pslverr_o, data_o, bit_timing_o, regen_o, regen_sync_o, regen_ss_o;
	sbt_count_t  bit_count_o;
	sbt_count_t  tgt [6];
	logic        alt, exp_add;
	logic [15:0] na, ns;
	int          err_count = 0, samples_checked = 0, cyc = 0, n;
	sbt_top uut (.clock_i(clock_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i),
		.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
		.pready_o(pready_o), .pslverr_o(pslverr_o), .line_i(line), .auto_sync_i(auto_sync_i),
		.data_o(data_o), .bit_timing_o(bit_timing_o), .regen_o(regen_o), .regen_sync_o(regen_sync_o),
		.regen_ss_o(regen_ss_o), .bit_count_o(bit_count_o));
	sbt_line_model #(.SPACE_LEN(20)) u_line (.clock_i(clock_i), .rstn_i(rstn_i), .go_i(go), .line_o(line));
	function automatic logic is_early(input sbt_count_t t);
		return t >= 7'h40;
	endfunction : is_early
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clock_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clock_i);
		penable_i <= 1'b1;
		do @(posedge clock_i); while (pready_o !== 1'b1);
		rd = prdata_o;
		er = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask : apb
	task automatic final_report;
		$display("checked %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : final_report
	initial begin
		clock_i = 1'b0;
		forever #50 clock_i = ~clock_i;
	end
	always @(posedge clock_i) begin
		cyc <= cyc + 1;
		if (cyc == 95000) begin
			err_count++;
			final_report();
		end
	end
	initial begin
		{rstn_i, psel_i, penable_i, pwrite_i, auto_sync_i, go, paddr_i, pwdata_i} = '0;
		void'($urandom(32'h25fd));
		repeat (20) @(posedge clock_i);
		rstn_i <= 1'b1;
		apb(1'b1, 12'hFF0, $urandom());
		`CHK("unmapped err", 1'b1, er)
		apb(1'b0, 12'h00C, 32'h0);
		`CHK("unmapped data", 32'h0, rd)
		apb(1'b0, `SBT_OFF_CTRL, 32'h0);
		`CHK("ctrl reset", `SBT_CTRL_RST, rd)
		apb(1'b0, `SBT_OFF_STAT, 32'h0);
		`CHK("last corr", SBT_CORR_NONE, rd[13:11])
		for (int i = 0; i < 4; i++) begin
			auto_sync_i <= 1'($urandom());
			apb(1'b1, `SBT_OFF_CTRL, 32'h00000101 | (i << 2));
			@(posedge clock_i);
			exp_sync = i[0] ? i[1] : auto_sync_i;
			`CHK("sync sel", exp_sync, regen_sync_o)
			`CHK("ss sel", !exp_sync, regen_ss_o)
		end
		apb(1'b1, `SBT_OFF_CTRL, 32'h0000010E);
		apb(1'b1, `SBT_OFF_CORR, 32'h0);
		{na, ns} = '0;
		alt = 1'b0;
		tgt = '{7'h05, 7'h3F, 7'h40, 7'h41 + 7'($urandom_range(62)), 7'h00, 7'h00};
		foreach (tgt[i]) begin
			n = 0;
			while (bit_count_o !== tgt[i] && n < 20000) begin
				@(posedge clock_i);
				n++;
			end
			`CHK("count reached", tgt[i], bit_count_o)
			go <= 1'b1;
			@(posedge clock_i);
			go <= 1'b0;
			// at the reference count corrections alternate, sub first
			exp_add = (tgt[i] == 7'h00) ? alt : is_early(tgt[i]);
			if (tgt[i] == 7'h00) alt = ~alt;
			if (exp_add) na++;
			else ns++;
			repeat (8) @(posedge clock_i);
			apb(1'b0, `SBT_OFF_CORR, 32'h0);
			`CHK("corr count", {ns, na}, rd)
			apb(1'b0, `SBT_OFF_STAT, 32'h0);
			`CHK("corr kind", exp_add ? SBT_CORR_ADD : SBT_CORR_SUB, rd[13:11])
			repeat (24) @(posedge clock_i);
		end
		apb(1'b1, `SBT_OFF_CORR, 32'h0);
		apb(1'b0, `SBT_OFF_CORR, 32'h0);
		`CHK("corr clear", 32'h0, rd)
		final_report();
	end
endmodule : sbt_top_tb
